//--- rtl/ubm_pkg.sv
// shared constants and frame helpers for the address-filtering serial link
// Behaviour
// - filter on drops frames without address mark
// - frame type is first stop or ninth bit
// - frame type one means address, zero data
// - transmitter ignores the address filter bit
// - master sends nine-bit frames, ninth marks address
// - slave software toggles filter around its data
// - five-to-eight bit sender uses two stop bits
// - data location: writes transmit, reads receive
// - unused upper bits ignored on send, zero on receive
// - data write ignored while transmit buffer full
// - buffered byte loads shifter when idle, shifts out
// - receive buffer is two-entry fifo, read advances
// - receive flag means unread data; disable flushes
// - transmit-done sets at frame end, buffer empty
// - buffer-empty flag high when writable, after reset
// - frame error follows head entry until read
// - overrun when fifo full, shifter full, start seen
// - parity error follows head entry when checked
// - double speed halves divisor, sixteen to eight
// - software writes zeros into error flag positions
// - filter unavailable in enhanced serial mode
// - software reads ninth bit before low byte
// - software writes ninth bit before low byte
package ubm_pkg;
    localparam int          REG_AW         = 3;
    // device register map
    localparam logic [2:0]  ADDR_DATA      = 3'h0;
    localparam logic [2:0]  ADDR_CSA       = 3'h1;
    localparam logic [2:0]  ADDR_CSB       = 3'h2;
    localparam logic [2:0]  ADDR_CSC       = 3'h3;
    localparam logic [2:0]  ADDR_BAUD      = 3'h4;
    // serial_control_status_a bits
    localparam int          BIT_RX_DONE    = 7;
    localparam int          BIT_TX_DONE    = 6;
    localparam int          BIT_TX_EMPTY   = 5;
    localparam int          BIT_FRAME_ERR  = 4;
    localparam int          BIT_OVERRUN    = 3;
    localparam int          BIT_PARITY_ERR = 2;
    localparam int          BIT_DBL_SPEED  = 1;
    localparam int          BIT_FILTER     = 0;
    // control b bits
    localparam int          BIT_RX_EN      = 4;
    localparam int          BIT_TX_EN      = 3;
    localparam int          BIT_SIZE_HI    = 2;
    localparam int          BIT_RX_NINTH   = 1;
    localparam int          BIT_TX_NINTH   = 0;
    // control c bits
    localparam int          BIT_ENHANCED   = 7;
    localparam int          BIT_PAR_EN     = 5;
    localparam int          BIT_PAR_ODD    = 4;
    localparam int          BIT_STOP_SEL   = 3;
    localparam int          BIT_SIZE_LO    = 1;
    localparam logic [7:0]  CSC_RESET      = 8'h06;
    localparam logic [7:0]  BAUD_RESET     = 8'h00;
    localparam logic [2:0]  SIZE_NINE      = 3'h7;
    // oversampling: last sample index and mid point
    localparam logic [3:0]  OS_LAST_NORM   = 4'hf;
    localparam logic [3:0]  OS_LAST_DBL    = 4'h7;
    localparam logic [3:0]  OS_HALF_NORM   = 4'h7;
    localparam logic [3:0]  OS_HALF_DBL    = 4'h3;
    // receive fifo entry layout
    localparam int          ENT_FE         = 9;
    localparam int          ENT_PE         = 10;
    // master register map
    localparam logic [2:0]  M_ADDR_DATA    = 3'h0;
    localparam logic [2:0]  M_ADDR_CTRL    = 3'h1;
    localparam logic [2:0]  M_ADDR_BAUD    = 3'h2;
    localparam int          M_BIT_TYPE     = 3;
    localparam int          M_BIT_PAR_EN   = 5;
    localparam int          M_BIT_PAR_ODD  = 4;
    localparam int          M_BIT_DBL      = 6;
    localparam logic [7:0]  M_CTRL_RESET   = 8'h07;

    function automatic logic [3:0] data_bits(input logic [2:0] code);
        return (code == SIZE_NINE) ? 4'h9 : 4'h5 + {2'b00, code[1:0]};
    endfunction

    function automatic logic [8:0] mask_bits(input logic [8:0] d, input logic [3:0] n);
        return d & ~(9'h1ff << n);
    endfunction

    // start bit, n data bits lsb first, optional parity, ones above
    function automatic logic [12:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                                input logic pe, input logic odd);
        logic [12:0] w;
        logic        p;
        w = 13'h1ffe;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < n) begin
                w[i+1] = d[i];
                p      = p ^ d[i];
            end
        end
        if (pe) begin
            w[n+4'h1] = p;
        end
        return w;
    endfunction
endpackage

//--- rtl/ubm_link_if.sv
// serial line pair between the filtering device and the bus master
interface ubm_link_if;
    logic devTx;
    logic hostTx;
    modport device (output devTx,  input hostTx);
    modport host   (output hostTx, input devTx);
endinterface

//--- rtl/ubm_device.sv
// filtering serial transceiver: data buffers, status flags, address filter
//
// Added by the designer: the register addresses and the plain strobed port.
module ubm_device (
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    ubm_link_if.device                      link,
    input  wire logic [ubm_pkg::REG_AW-1:0] addr,
    input  wire logic [7:0]                 wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [7:0]                 rdata
);
    import ubm_pkg::*;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_BITS  = 4'b0100,
        RX_STOP  = 4'b1000
    } ubm_rx_state_t;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic       filter_q, dbl_q, rxEn_q, txEn_q, sizeHi_q, txNinth_q;
    logic       enh_q, parEn_q, parOdd_q, stopSel_q;
    logic [1:0] sizeLo_q;
    logic [7:0] baud_q;
    logic       wrData, wrCsa, wrCsb, wrCsc, wrBaud;

    always_comb begin
        wrData = 1'b0;
        wrCsa  = 1'b0;
        wrCsb  = 1'b0;
        wrCsc  = 1'b0;
        wrBaud = 1'b0;
        if (addr == ADDR_DATA) begin
            wrData = wr;
        end else if (addr == ADDR_CSA) begin
            wrCsa = wr;
        end else if (addr == ADDR_CSB) begin
            wrCsb = wr;
        end else if (addr == ADDR_CSC) begin
            wrCsc = wr;
        end else if (addr == ADDR_BAUD) begin
            wrBaud = wr;
        end
    end

    // error positions of a status write are dropped
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            filter_q  <= 1'b0;
            dbl_q     <= 1'b0;
            rxEn_q    <= 1'b0;
            txEn_q    <= 1'b0;
            sizeHi_q  <= 1'b0;
            txNinth_q <= 1'b0;
            enh_q     <= CSC_RESET[BIT_ENHANCED];
            parEn_q   <= CSC_RESET[BIT_PAR_EN];
            parOdd_q  <= CSC_RESET[BIT_PAR_ODD];
            stopSel_q <= CSC_RESET[BIT_STOP_SEL];
            sizeLo_q  <= CSC_RESET[BIT_SIZE_LO+:2];
            baud_q    <= BAUD_RESET;
        end else begin
            if (wrCsa) begin
                filter_q <= wdata[BIT_FILTER];
                dbl_q    <= wdata[BIT_DBL_SPEED];
            end
            if (wrCsb) begin
                rxEn_q    <= wdata[BIT_RX_EN];
                txEn_q    <= wdata[BIT_TX_EN];
                sizeHi_q  <= wdata[BIT_SIZE_HI];
                txNinth_q <= wdata[BIT_TX_NINTH];
            end
            if (wrCsc) begin
                enh_q     <= wdata[BIT_ENHANCED];
                parEn_q   <= wdata[BIT_PAR_EN];
                parOdd_q  <= wdata[BIT_PAR_ODD];
                stopSel_q <= wdata[BIT_STOP_SEL];
                sizeLo_q  <= wdata[BIT_SIZE_LO+:2];
            end
            if (wrBaud) begin
                baud_q <= wdata;
            end
        end
    end

    logic [3:0] nBits, osLast, osHalf;
    logic       isNine, tick;
    logic [7:0] baudCnt_q;
    assign nBits  = data_bits({sizeHi_q, sizeLo_q});
    assign isNine = {sizeHi_q, sizeLo_q} == SIZE_NINE;
    assign osLast = dbl_q ? OS_LAST_DBL : OS_LAST_NORM;
    assign osHalf = dbl_q ? OS_HALF_DBL : OS_HALF_NORM;
    assign tick   = baudCnt_q == 8'h00;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            baudCnt_q <= 8'h00;
        end else begin
            baudCnt_q <= tick ? baud_q : baudCnt_q - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // transmitter; filter bit has no path here
    // ------------------------------------------------------------
    logic        txBufV_q, txBusy_q, txDone_q, txd_q, load, txEnd;
    logic [8:0]  txBuf_q;
    logic [12:0] txWord_q;
    logic [3:0]  txLeft_q, txCnt_q;
    assign load  = txEn_q && !txBusy_q && txBufV_q;
    assign txEnd = txBusy_q && tick && txCnt_q == osLast && txLeft_q == 4'h1;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txBufV_q <= 1'b0;
            txBuf_q  <= 9'h000;
        end else if (load) begin
            txBufV_q <= 1'b0;
        end else if (wrData && !txBufV_q) begin
            txBufV_q <= 1'b1;
            txBuf_q  <= mask_bits({txNinth_q, wdata}, nBits);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txBusy_q <= 1'b0;
            txWord_q <= 13'h1fff;
            txLeft_q <= 4'h0;
            txCnt_q  <= 4'h0;
        end else if (load) begin
            txBusy_q <= 1'b1;
            txWord_q <= build_frame(txBuf_q, nBits, parEn_q, parOdd_q);
            txLeft_q <= 4'h1 + nBits + {3'b000, parEn_q} + (stopSel_q ? 4'h2 : 4'h1);
            txCnt_q  <= 4'h0;
        end else if (txBusy_q && tick) begin
            if (txCnt_q == osLast) begin
                txCnt_q  <= 4'h0;
                txWord_q <= {1'b1, txWord_q[12:1]};
                txLeft_q <= txLeft_q - 4'h1;
                txBusy_q <= txLeft_q != 4'h1;
            end else begin
                txCnt_q <= txCnt_q + 4'h1;
            end
        end
    end

    // set beats a one-write clear in the same cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txDone_q <= 1'b0;
            txd_q    <= 1'b1;
        end else begin
            if (txEnd && !txBufV_q) begin
                txDone_q <= 1'b1;
            end else if (wrCsa && wdata[BIT_TX_DONE]) begin
                txDone_q <= 1'b0;
            end
            txd_q <= txBusy_q ? txWord_q[0] : 1'b1;
        end
    end
    assign link.devTx = txd_q;

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    ubm_rx_state_t rxSt_q;
    logic        rxMeta_q, rxS_q, ovPend_q, frameDone, keep, frameType, parBad;
    logic [3:0]  rxCnt_q, rxIdx_q, rxLast;
    logic [9:0]  rxShift_q;
    logic [8:0]  rxData;
    logic [10:0] newEnt;
    assign rxLast    = nBits + {3'b000, parEn_q} - 4'h1;
    assign frameDone = rxSt_q == RX_STOP && tick && rxCnt_q == osLast;
    assign rxData    = mask_bits(rxShift_q[8:0], nBits);
    assign parBad    = parEn_q && (rxShift_q[nBits] != (parOdd_q ^ (^rxData)));
    assign frameType = isNine ? rxShift_q[8] : rxS_q;
    assign keep      = !(filter_q && !enh_q && !frameType);
    assign newEnt    = {parBad, !rxS_q, rxData};

    // second stage alone feeds the receive logic
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rxMeta_q <= 1'b1;
            rxS_q    <= 1'b1;
        end else begin
            rxMeta_q <= link.hostTx;
            rxS_q    <= rxMeta_q;
        end
    end

    logic       heldV_q, heldV_d, head_q, head_d;
    logic [1:0] cnt_q, cnt_d;
    logic [10:0] fifo_q [2];
    logic [10:0] fifo_d [2];
    logic [10:0] held_q, held_d;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rxSt_q    <= RX_IDLE;
            rxCnt_q   <= 4'h0;
            rxIdx_q   <= 4'h0;
            rxShift_q <= 10'h000;
            ovPend_q  <= 1'b0;
        end else if (!rxEn_q) begin
            rxSt_q <= RX_IDLE;
        end else begin
            case (rxSt_q)
                RX_IDLE: begin
                    if (!rxS_q) begin
                        rxSt_q   <= RX_START;
                        rxCnt_q  <= 4'h0;
                        ovPend_q <= heldV_q;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        if (rxCnt_q != osHalf) begin
                            rxCnt_q <= rxCnt_q + 4'h1;
                        end else if (rxS_q) begin
                            rxSt_q <= RX_IDLE;
                        end else begin
                            rxSt_q    <= RX_BITS;
                            rxCnt_q   <= 4'h0;
                            rxIdx_q   <= 4'h0;
                            rxShift_q <= 10'h000;
                        end
                    end
                end
                RX_BITS: begin
                    if (tick) begin
                        if (rxCnt_q != osLast) begin
                            rxCnt_q <= rxCnt_q + 4'h1;
                        end else begin
                            rxCnt_q            <= 4'h0;
                            rxShift_q[rxIdx_q] <= rxS_q;
                            rxIdx_q            <= rxIdx_q + 4'h1;
                            if (rxIdx_q == rxLast) begin
                                rxSt_q <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        rxCnt_q <= rxCnt_q + 4'h1;
                        if (rxCnt_q == osLast) begin
                            rxSt_q <= RX_IDLE;
                        end
                    end
                end
                default: rxSt_q <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // two-entry receive fifo plus the frame waiting in the shifter
    // ------------------------------------------------------------
    logic pop, newV, ovr_q;
    assign pop  = rd && addr == ADDR_DATA && cnt_q != 2'h0;
    assign newV = frameDone && keep;

    always_comb begin
        fifo_d  = fifo_q;
        held_d  = held_q;
        heldV_d = heldV_q;
        cnt_d   = cnt_q - {1'b0, pop};
        head_d  = head_q ^ pop;
        if (heldV_q && cnt_d != 2'h2) begin
            fifo_d[head_d ^ cnt_d[0]] = held_q;
            cnt_d   = cnt_d + 2'h1;
            heldV_d = 1'b0;
        end
        if (newV) begin
            if (cnt_d != 2'h2) begin
                fifo_d[head_d ^ cnt_d[0]] = newEnt;
                cnt_d = cnt_d + 2'h1;
            end else if (!heldV_d) begin
                held_d  = newEnt;
                heldV_d = 1'b1;
            end
        end
        if (!rxEn_q) begin
            cnt_d   = 2'h0;
            heldV_d = 1'b0;
        end
    end

    // a frame whose start saw an overrun sets the flag; it is lost unless a read made room
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fifo_q  <= '{default: 11'h000};
            held_q  <= 11'h000;
            heldV_q <= 1'b0;
            cnt_q   <= 2'h0;
            head_q  <= 1'b0;
            ovr_q   <= 1'b0;
        end else begin
            fifo_q  <= fifo_d;
            held_q  <= held_d;
            heldV_q <= heldV_d;
            cnt_q   <= cnt_d;
            head_q  <= head_d;
            if (!rxEn_q) begin
                ovr_q <= 1'b0;
            end else if (newV && ovPend_q) begin
                ovr_q <= 1'b1;
            end else if (pop) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [10:0] headEnt;
    logic        rxAny;
    assign rxAny   = cnt_q != 2'h0;
    assign headEnt = rxAny ? fifo_q[head_q] : 11'h000;

    // ninth bit read does not advance the fifo
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (!rd) begin
            rdata <= 8'h00;
        end else if (addr == ADDR_DATA) begin
            rdata <= headEnt[7:0];
        end else if (addr == ADDR_CSA) begin
            rdata <= {rxAny, txDone_q, !txBufV_q, headEnt[ENT_FE], ovr_q,
                      headEnt[ENT_PE], dbl_q, filter_q};
        end else if (addr == ADDR_CSB) begin
            rdata <= {3'b000, rxEn_q, txEn_q, sizeHi_q, headEnt[8], txNinth_q};
        end else if (addr == ADDR_CSC) begin
            rdata <= {enh_q, 1'b0, parEn_q, parOdd_q, stopSel_q, sizeLo_q, 1'b0};
        end else if (addr == ADDR_BAUD) begin
            rdata <= baud_q;
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

//--- rtl/ubm_master.sv
// bus master end: sends address and data frames to filtering slaves
module ubm_master (
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    ubm_link_if.host                        link,
    input  wire logic [ubm_pkg::REG_AW-1:0] addr,
    input  wire logic [7:0]                 wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [7:0]                 rdata
);
    import ubm_pkg::*;

    // ------------------------------------------------------------
    // registers and baud tick
    // ------------------------------------------------------------
    logic [7:0]  ctrl_q, baud_q, baudCnt_q;
    logic [12:0] word_q;
    logic [3:0]  left_q, cnt_q, nBits, osLast;
    logic        busy_q, txd_q, tick, start, isNine;
    assign nBits  = data_bits(ctrl_q[2:0]);
    assign isNine = ctrl_q[2:0] == SIZE_NINE;
    assign osLast = ctrl_q[M_BIT_DBL] ? OS_LAST_DBL : OS_LAST_NORM;
    assign tick   = baudCnt_q == 8'h00;
    assign start  = wr && addr == M_ADDR_DATA && !busy_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q    <= M_CTRL_RESET;
            baud_q    <= BAUD_RESET;
            baudCnt_q <= 8'h00;
        end else begin
            if (wr && addr == M_ADDR_CTRL) begin
                ctrl_q <= wdata;
            end
            if (wr && addr == M_ADDR_BAUD) begin
                baud_q <= wdata;
            end
            baudCnt_q <= tick ? baud_q : baudCnt_q - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // frame shifter; short frames carry the type in the first stop
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            word_q <= 13'h1fff;
            left_q <= 4'h0;
            cnt_q  <= 4'h0;
        end else if (start) begin
            busy_q <= 1'b1;
            // ninth bit is the frame type on nine-bit frames
            word_q <= build_frame(mask_bits({ctrl_q[M_BIT_TYPE], wdata}, nBits), nBits,
                                  ctrl_q[M_BIT_PAR_EN], ctrl_q[M_BIT_PAR_ODD]);
            // two stops for short frames, type goes in the first
            left_q <= 4'h1 + nBits + {3'b000, ctrl_q[M_BIT_PAR_EN]} +
                      (isNine ? 4'h1 : 4'h2);
            cnt_q  <= 4'h0;
        end else if (busy_q && tick) begin
            if (cnt_q == osLast) begin
                cnt_q  <= 4'h0;
                word_q <= {1'b1, word_q[12:1]};
                left_q <= left_q - 4'h1;
                busy_q <= left_q != 4'h1;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // short data frames hold the first stop low: a deliberate type mark
    logic firstStop;
    assign firstStop = left_q == 4'h2 && !isNine && !ctrl_q[M_BIT_TYPE];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txd_q <= 1'b1;
            rdata <= 8'h00;
        end else begin
            txd_q <= busy_q ? (word_q[0] && !firstStop) : 1'b1;
            if (rd && addr == M_ADDR_DATA) begin
                rdata <= {7'h00, busy_q};
            end else if (rd && addr == M_ADDR_CTRL) begin
                rdata <= ctrl_q;
            end else if (rd && addr == M_ADDR_BAUD) begin
                rdata <= baud_q;
            end else begin
                rdata <= 8'h00;
            end
        end
    end
    assign link.hostTx = txd_q;
endmodule

//--- test/ubm_link_checker.sv
// serial line checks between the two ends of the filtering link
module ubm_link_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic devTx,
    input wire logic hostTx
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] hostLow_q;
    logic [8:0] devLow_q;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // low run counters; the bound below holds for baud 0 only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hostLow_q <= 9'h000;
            devLow_q  <= 9'h000;
        end else begin
            hostLow_q <= hostTx ? 9'h000 : hostLow_q + 9'h001;
            devLow_q  <= devTx ? 9'h000 : devLow_q + 9'h001;
        end
    end
    reset_idle_a: assert property ($rose(rstn) |-> hostTx && devTx)
        else $error("serial line not idle after reset");
    host_bit_a: assert property ($changed(hostTx) |=> $stable(hostTx) [*7])
        else $error("master line bit shorter than eight clocks");
    dev_bit_a: assert property ($changed(devTx) |=> $stable(devTx) [*7])
        else $error("device line bit shorter than eight clocks");
    host_stop_a: assert property (hostLow_q < 9'h0c8)
        else $error("master line low past a whole frame");
    dev_stop_a: assert property (devLow_q < 9'h0c8)
        else $error("device line low past a whole frame");
    dev_start_a: assert property ($fell(devTx) |-> $past(devTx, 8))
        else $error("device start bit without a stop bit before it");
endmodule

//--- test/ubm_link_test.sv
// self-checking bench: master and filtering device joined over the serial link
module ubm_link_test;
    timeunit 1ns;
    timeprecision 100ps;
    import ubm_pkg::*;
    logic       clk_sys;
    logic       rstn;
    logic [2:0] busAddr  [2];
    logic [7:0] busWdata [2];
    logic       busWr    [2];
    logic       busRd    [2];
    logic [7:0] rdDev;
    logic [7:0] rdHost;
    logic [7:0] lf;
    logic [7:0] q;
    logic [7:0] vals     [4];
    int         n_errors;
    int         n_tests;
    ubm_link_if ubm_link_if_inst ();
    ubm_device ubm_device_inst (.clk_sys(clk_sys), .rstn(rstn), .link(ubm_link_if_inst),
        .addr(busAddr[0]), .wdata(busWdata[0]), .wr(busWr[0]), .rd(busRd[0]), .rdata(rdDev));
    ubm_master ubm_master_inst (.clk_sys(clk_sys), .rstn(rstn), .link(ubm_link_if_inst),
        .addr(busAddr[1]), .wdata(busWdata[1]), .wr(busWr[1]), .rd(busRd[1]), .rdata(rdHost));
    ubm_link_checker ubm_link_checker_inst (.clk_sys(clk_sys), .rstn(rstn),
        .devTx(ubm_link_if_inst.devTx), .hostTx(ubm_link_if_inst.hostTx));
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input int m, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        busAddr[m]  <= a;
        busWdata[m] <= d;
        busWr[m]    <= 1'b1;
        @(posedge clk_sys);
        busWr[m]    <= 1'b0;
    endtask
    task rdc(input int m, input logic [2:0] a, input logic [7:0] e, input logic [7:0] mk);
        @(posedge clk_sys);
        busAddr[m] <= a;
        busRd[m]   <= 1'b1;
        @(posedge clk_sys);
        busRd[m]   <= 1'b0;
        #1 q = m ? rdHost : rdDev;
        if (mk != 8'h00) chk(q & mk, e & mk);
    endtask
    // polls the master busy bit; the receiver is done mid first stop bit, just before the master
    task sendm(input logic [7:0] c, input logic [7:0] d);
        int i;
        wr(1, M_ADDR_CTRL, c);
        rdc(1, M_ADDR_CTRL, c, 8'hff);
        wr(1, M_ADDR_DATA, d);
        i = 0;
        do begin
            rdc(1, M_ADDR_DATA, 8'h00, 8'h00);
            i++;
        end while (q[0] !== 1'b0 && i < 400);
        chk({7'h00, q[0]}, 8'h00);
        repeat (20) @(posedge clk_sys);
    endtask
    task frm(input logic [7:0] c, d, st, mk, ex);
        sendm(c, d);
        rdc(0, ADDR_CSA, st, mk);
        if (st[7] && c[2:0] == 3'h7) rdc(0, ADDR_CSB, {6'h0, c[3], 1'b0}, 8'h02);
        if (st[7]) rdc(0, ADDR_DATA, ex, 8'hff);
    endtask
    task txchk(input logic [7:0] d);
        int         i;
        logic [8:0] s;
        for (i = 0; i < 200 && ubm_link_if_inst.devTx !== 1'b0; i++) @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
        for (i = 0; i < 9; i++) begin
            repeat (16) @(posedge clk_sys);
            s = {ubm_link_if_inst.devTx, s[8:1]};
        end
        chk(s[7:0], d);
        chk({7'h0, s[8]}, 8'h01);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // about 17 frames of some 200 clocks each, with ample margin
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        give_verdict;
    end
    initial begin
        rstn = 1'b0;
        lf = 8'h62;
        n_errors = 0;
        n_tests = 0;
        for (int m = 0; m < 2; m++) begin
            busAddr[m] = 3'h0;
            busWdata[m] = 8'h00;
            busWr[m] = 1'b0;
            busRd[m] = 1'b0;
        end
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        rdc(0, ADDR_CSA, 8'h20, 8'hff);
        wr(0, ADDR_DATA, 8'ha5);
        rdc(0, ADDR_CSA, 8'h00, 8'h20);
        wr(0, ADDR_DATA, 8'h3c);
        wr(0, ADDR_CSA, 8'h01);
        wr(0, ADDR_CSB, 8'h18);
        txchk(8'ha5);
        repeat (16) @(posedge clk_sys);
        rdc(0, ADDR_CSA, 8'h60, 8'h60);
        wr(0, ADDR_CSA, 8'h40);
        rdc(0, ADDR_CSA, 8'h00, 8'h40);
        $display("transmit test done");
        wr(0, ADDR_CSC, 8'h04);
        wr(0, ADDR_CSA, 8'h01);
        frm(8'h0a, 8'hff, 8'h80, 8'h90, 8'h7f);
        lf = nxt(lf);
        frm(8'h02, lf, 8'h00, 8'h80, 8'h00);
        wr(0, ADDR_CSA, 8'h00);
        frm(8'h02, lf, 8'h90, 8'h90, lf & 8'h7f);
        wr(0, ADDR_CSB, 8'h1c);
        wr(0, ADDR_CSC, 8'h06);
        for (int k = 0; k < 6; k++) begin
            lf = nxt(lf);
            wr(0, ADDR_CSA, {7'h0, lf[7]});
            frm({4'h0, lf[0], 3'h7}, lf, {lf[0] | !lf[7], 7'h0}, 8'h9c, lf);
        end
        wr(0, ADDR_CSC, 8'h86);
        wr(0, ADDR_CSA, 8'h01);
        frm(8'h07, lf, 8'h80, 8'h9c, lf);
        wr(0, ADDR_CSC, 8'h06);
        $display("filter test done");
        wr(0, ADDR_CSA, 8'h00);
        for (int k = 0; k < 4; k++) begin
            lf = nxt(lf);
            vals[k] = lf;
            sendm(8'h0f, lf);
        end
        rdc(0, ADDR_CSA, 8'h88, 8'h88);
        for (int k = 0; k < 3; k++) rdc(0, ADDR_DATA, vals[k], 8'hff);
        rdc(0, ADDR_CSA, 8'h00, 8'h80);
        sendm(8'h0f, 8'h5a);
        rdc(0, ADDR_CSA, 8'h80, 8'h80);
        wr(0, ADDR_CSB, 8'h0c);
        rdc(0, ADDR_CSA, 8'h00, 8'h80);
        wr(0, ADDR_CSB, 8'h1c);
        $display("fifo test done");
        wr(0, ADDR_CSC, 8'h26);
        lf = nxt(lf);
        frm(8'h37, lf, 8'h84, 8'h84, lf);
        wr(0, ADDR_CSC, 8'h06);
        wr(0, ADDR_CSA, 8'h02);
        lf = nxt(lf);
        frm(8'h47, lf, 8'h80, 8'h80, lf);
        $display("error and speed test done");
        give_verdict;
    end
endmodule
